// ### hdl/sps_consts.svh
// Constants of the stepper phase sequencer: offsets, fields, patterns, timing
// Included by bare name; guarded against double inclusion
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_AW 8
`define SPS_DW 32
`define SPS_REG_CTRL 8'h00
`define SPS_REG_STAT 8'h04
`define SPS_REG_STEPS 8'h08
`define SPS_REG_POS 8'h0c
`define SPS_CTRL_EN 0
`define SPS_CTRL_RST 1'b1
`define SPS_ST_IDX 0
`define SPS_IDX_W 3
`define SPS_ST_MODE 3
`define SPS_ST_DIR 4
`define SPS_ST_EN 5
`define SPS_ST_INIT 6
`define SPS_ST_LONG 7
`define SPS_ST_PH 8
`define SPS_PH_W 4
`define SPS_PH_W1P 3
`define SPS_PH_W1N 2
`define SPS_PH_W2P 1
`define SPS_PH_W2N 0
`define SPS_CNT_W 16
`define SPS_INIT_IDX 3'h0
`define SPS_STEP_HALF 3'h1
`define SPS_STEP_FULL 3'h2
`define SPS_PAT0 4'h9
`define SPS_PAT1 4'h8
`define SPS_PAT2 4'ha
`define SPS_PAT3 4'h2
`define SPS_PAT4 4'h6
`define SPS_PAT5 4'h4
`define SPS_PAT6 4'h5
`define SPS_PAT7 4'h1
`define SPS_CLK_MHZ 250
`define SPS_INIT_MIN_NS 10000
`define SPS_INIT_MIN_CYC ((`SPS_INIT_MIN_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_INIT_CNT_W 12
`define SPS_SYNC_W 5
`define SPS_SY_TOG 4
`define SPS_SY_DIR 3
`define SPS_SY_MODE 2
`define SPS_SY_INIT 1
`define SPS_SY_EN 0
`endif

// ### hdl/sps_pkg.sv
// Types of the stepper phase sequencer
// Assumes sps_consts.svh for all widths
`include "sps_consts.svh"
package sps_pkg;
  typedef logic [`SPS_PH_W-1:0] sps_phase_type;
  typedef logic [`SPS_SYNC_W-1:0] sps_sync_vec_type;
  typedef struct packed {
    logic [`SPS_IDX_W-1:0] idx;
    sps_phase_type phase;
    logic tog_d1;
    logic tog_seen;
    logic soft_en;
    logic [`SPS_CNT_W-1:0] steps;
    logic [`SPS_CNT_W-1:0] pos;
    logic [`SPS_INIT_CNT_W-1:0] init_cnt;
    logic init_long;
    logic [`SPS_DW-1:0] rdata;
  } sps_main_type;
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic tog;
    logic dir;
    logic mode;
  } sps_cap_type;
  typedef struct packed {
    sps_sync_vec_type s1;
    sps_sync_vec_type s2;
  } sps_sync_type;
endpackage

// ### hdl/sps_step_if.sv
// Step event carrier from the step clock domain to the system domain
// Assumes the source changes all three only on a rising step clock edge
`timescale 1ns/1ps
interface sps_step_if;
  logic tog;
  logic dir;
  logic mode;
  modport source (output tog, output dir, output mode);
  modport sink (input tog, input dir, input mode);
endinterface

// ### hdl/sps_sync.sv
// Two-stage synchroniser for step carrier, init and enable into I_CLK
// Assumes inputs are quasi-static or toggle-coded
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  sps_step_if.sink i_step,
  input wire logic i_init_n,
  input wire logic i_enable,
  output sps_pkg::sps_sync_vec_type o_q
);
  import sps_pkg::*;
  sps_sync_type st_reg;
  sps_sync_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = {i_step.tog, i_step.dir, i_step.mode, i_init_n, i_enable};
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.s2;
endmodule // sps_sync

// ### hdl/sps_step_capture.sv
// Step clock domain: toggles per rising edge, captures direction and mode
// Assumes the host meets hold times around each rising step edge
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_step_capture (
  input wire logic i_step_clk,
  input wire logic i_rst,
  input wire logic i_dir,
  input wire logic i_mode,
  sps_step_if.source o_step
);
  import sps_pkg::*;
  sps_cap_type st_reg;
  sps_cap_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rst_s1 = i_rst;
    st_next.rst_s2 = st_reg.rst_s1;
    if (st_reg.rst_s2) begin
      st_next.tog = 1'b0;
      st_next.dir = 1'b0;
      st_next.mode = 1'b0;
    end else begin
      st_next.tog = ~st_reg.tog;
      st_next.dir = i_dir;
      st_next.mode = i_mode;
    end
  end

  // Rising edge only; falling edges never touch the carrier
  always_ff @(posedge i_step_clk) begin
    st_reg <= st_next;
  end

  assign o_step.tog = st_reg.tog;
  assign o_step.dir = st_reg.dir;
  assign o_step.mode = st_reg.mode;
endmodule // sps_step_capture

// ### hdl/sps_top.sv
// Stepper phase sequencer: step tracking, phase outputs, register port
// Assumes step clock from the host; register port and pins sync to I_CLK
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_STEP_CLK,
  input wire logic I_ROTATION_DIRECTION_SELECT,
  input wire logic I_EXCITATION_MODE,
  input wire logic I_INIT_LOW_INPUT_N,
  input wire logic I_OUTPUT_ENABLE,
  input wire logic [`SPS_AW-1:0] I_ADDR,
  input wire logic [`SPS_DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`SPS_DW-1:0] O_RDATA,
  output logic O_WIND1_POS,
  output logic O_WIND1_NEG,
  output logic O_WIND2_POS,
  output logic O_WIND2_NEG
);
  import sps_pkg::*;

  sps_main_type st_reg;
  sps_main_type st_next;
  sps_sync_vec_type sync_q;
  logic init_ok;
  logic en_ok;
  logic mode_s;
  logic dir_s;
  logic step_evt;
  logic step_go;
  logic [`SPS_IDX_W-1:0] delta;
  logic [`SPS_IDX_W-1:0] idx_step;
  logic [`SPS_CNT_W-1:0] pos_step;
  logic wr_ctrl;
  logic wr_steps;
  logic wr_pos;
  logic [`SPS_DW-1:0] rd_word;

  sps_step_if step_bus ();

  // Link side runs on the step clock itself
  sps_step_capture u_capture (
    .i_step_clk(I_STEP_CLK),
    .i_rst(I_RST),
    .i_dir(I_ROTATION_DIRECTION_SELECT),
    .i_mode(I_EXCITATION_MODE),
    .o_step(step_bus.source)
  );

  sps_sync u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_step(step_bus.sink),
    .i_init_n(I_INIT_LOW_INPUT_N),
    .i_enable(I_OUTPUT_ENABLE),
    .o_q(sync_q)
  );

  // Winding pattern {w1 pos, w1 neg, w2 pos, w2 neg}; even index drives two
  function automatic sps_phase_type phase_of(input logic [`SPS_IDX_W-1:0] idx);
    case (idx)
      3'h0: phase_of = `SPS_PAT0;
      3'h1: phase_of = `SPS_PAT1;
      3'h2: phase_of = `SPS_PAT2;
      3'h3: phase_of = `SPS_PAT3;
      3'h4: phase_of = `SPS_PAT4;
      3'h5: phase_of = `SPS_PAT5;
      3'h6: phase_of = `SPS_PAT6;
      3'h7: phase_of = `SPS_PAT7;
      default: phase_of = `SPS_PAT0;
    endcase
  endfunction

  assign init_ok = sync_q[`SPS_SY_INIT];
  assign en_ok = sync_q[`SPS_SY_EN] & st_reg.soft_en;
  assign mode_s = sync_q[`SPS_SY_MODE];
  assign dir_s = sync_q[`SPS_SY_DIR];

  // Toggle seen one stage late so direction and mode have settled
  assign step_evt = st_reg.tog_d1 ^ st_reg.tog_seen;
  assign step_go = step_evt & init_ok;

  // Full-step from an odd index lands on the next two-winding state
  assign delta = (mode_s | st_reg.idx[0]) ? `SPS_STEP_HALF : `SPS_STEP_FULL;
  assign idx_step = dir_s ? st_reg.idx - delta : st_reg.idx + delta;
  assign pos_step = dir_s ? st_reg.pos - `SPS_CNT_W'(delta) : st_reg.pos + `SPS_CNT_W'(delta);

  assign wr_ctrl = I_WR && (I_ADDR == `SPS_REG_CTRL);
  assign wr_steps = I_WR && (I_ADDR == `SPS_REG_STEPS);
  assign wr_pos = I_WR && (I_ADDR == `SPS_REG_POS);

  always_comb begin
    rd_word = '0;
    case (I_ADDR)
      `SPS_REG_CTRL: begin
        rd_word[`SPS_CTRL_EN] = st_reg.soft_en;
      end
      `SPS_REG_STAT: begin
        rd_word[`SPS_ST_IDX +: `SPS_IDX_W] = st_reg.idx;
        rd_word[`SPS_ST_MODE] = mode_s;
        rd_word[`SPS_ST_DIR] = dir_s;
        rd_word[`SPS_ST_EN] = sync_q[`SPS_SY_EN];
        rd_word[`SPS_ST_INIT] = init_ok;
        rd_word[`SPS_ST_LONG] = st_reg.init_long;
        rd_word[`SPS_ST_PH +: `SPS_PH_W] = st_reg.phase;
      end
      `SPS_REG_STEPS: begin
        rd_word[`SPS_CNT_W-1:0] = st_reg.steps;
      end
      `SPS_REG_POS: begin
        rd_word[`SPS_CNT_W-1:0] = st_reg.pos;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.tog_d1 = sync_q[`SPS_SY_TOG];
    st_next.tog_seen = st_reg.tog_d1;

    // Sequencer position
    if (!init_ok) begin
      st_next.idx = `SPS_INIT_IDX;
    end else if (step_evt) begin
      st_next.idx = idx_step;
    end

    // Outputs follow the position; all off while init low or gated off
    if (init_ok && en_ok) begin
      st_next.phase = phase_of(st_next.idx);
    end else begin
      st_next.phase = '0;
    end

    // Step count and half-step position; a step in a count-clear cycle still counts, a position write wins
    if (!init_ok) begin
      st_next.steps = '0;
      st_next.pos = '0;
    end else begin
      st_next.steps = wr_steps ? '0 : st_reg.steps;
      st_next.pos = wr_pos ? I_WDATA[`SPS_CNT_W-1:0] : st_reg.pos;
      if (step_evt) begin
        st_next.steps = st_next.steps + `SPS_CNT_W'(1);
        st_next.pos = wr_pos ? I_WDATA[`SPS_CNT_W-1:0] : pos_step;
      end
    end

    // Width of the last init pulse against the host minimum
    if (!init_ok) begin
      if (st_reg.init_cnt != `SPS_INIT_CNT_W'(`SPS_INIT_MIN_CYC)) begin
        st_next.init_cnt = st_reg.init_cnt + `SPS_INIT_CNT_W'(1);
      end
      st_next.init_long = (st_reg.init_cnt == `SPS_INIT_CNT_W'(`SPS_INIT_MIN_CYC));
    end else begin
      st_next.init_cnt = '0;
    end

    if (wr_ctrl) begin
      st_next.soft_en = I_WDATA[`SPS_CTRL_EN];
    end

    // Read data stand one cycle only
    st_next.rdata = I_RD ? rd_word : '0;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg <= '0;
      st_reg.idx <= `SPS_INIT_IDX;
      st_reg.soft_en <= `SPS_CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_RDATA = st_reg.rdata;
  assign O_WIND1_POS = st_reg.phase[`SPS_PH_W1P];
  assign O_WIND1_NEG = st_reg.phase[`SPS_PH_W1N];
  assign O_WIND2_POS = st_reg.phase[`SPS_PH_W2P];
  assign O_WIND2_NEG = st_reg.phase[`SPS_PH_W2N];

  // Checks on the system clock
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  chk_no_edge_hold: assert property (
    init_ok && !step_evt |=> st_reg.idx == $past(st_reg.idx)
  ) else $error("position moved without a step edge");

  chk_edge_moves: assert property (
    step_go |=> st_reg.idx != $past(st_reg.idx)
  ) else $error("step edge did not move position");

  chk_one_per_edge: assert property (
    step_go |=> !step_evt
  ) else $error("one step edge seen twice");

  chk_full_fwd: assert property (
    step_go && !mode_s && !dir_s && !st_reg.idx[0]
    |=> st_reg.idx == $past(st_reg.idx) + `SPS_STEP_FULL
  ) else $error("full-step forward moved wrong");

  chk_half_fwd: assert property (
    step_go && mode_s && !dir_s |=> st_reg.idx == $past(st_reg.idx) + `SPS_STEP_HALF
  ) else $error("half-step forward moved wrong");

  chk_half_rev: assert property (
    step_go && mode_s && dir_s |=> st_reg.idx == $past(st_reg.idx) - `SPS_STEP_HALF
  ) else $error("half-step reverse moved wrong");

  chk_full_rev: assert property (
    step_go && !mode_s && dir_s && !st_reg.idx[0]
    |=> st_reg.idx == $past(st_reg.idx) - `SPS_STEP_FULL
  ) else $error("full-step reverse moved wrong");

  chk_init_hold: assert property (
    !init_ok |=> st_reg.idx == `SPS_INIT_IDX && st_reg.phase == '0 && st_reg.steps == '0
  ) else $error("init low did not hold start and off");

  chk_init_ignores: assert property (
    !init_ok && step_evt ##1 !init_ok |=> st_reg.idx == `SPS_INIT_IDX
  ) else $error("step taken while init low");

  chk_start_state: assert property (
    !init_ok ##1 init_ok && en_ok && !step_evt
    |=> O_WIND1_POS && O_WIND2_NEG && !O_WIND1_NEG && !O_WIND2_POS
  ) else $error("start state is not winding one pos, two neg");

  chk_disable_off: assert property (
    !en_ok |=> !O_WIND1_POS && !O_WIND1_NEG && !O_WIND2_POS && !O_WIND2_NEG
  ) else $error("outputs on while disabled");

  chk_disable_track: assert property (
    !en_ok && step_go |=> st_reg.idx != $past(st_reg.idx) && st_reg.phase == '0
  ) else $error("position lost while disabled");

  chk_resume_phase: assert property (
    init_ok && en_ok |=> st_reg.phase == phase_of(st_reg.idx)
  ) else $error("outputs do not match reached position");

  chk_resume_edge: assert property (
    $rose(en_ok) && init_ok |=> st_reg.phase == phase_of(st_reg.idx) && st_reg.idx != `SPS_INIT_IDX
    || $past(st_reg.idx) == `SPS_INIT_IDX || $past(step_evt)
  ) else $error("enable restarted the sequence");

  chk_full_even: assert property (
    step_go && !mode_s |=> !st_reg.idx[0]
  ) else $error("full-step left a one-winding state");

  chk_mode_keep: assert property (
    step_go && !mode_s && !dir_s && st_reg.idx[0]
    |=> st_reg.idx == $past(st_reg.idx) + `SPS_STEP_HALF
  ) else $error("mode change lost the position");

  chk_half_odd: assert property (
    step_go && mode_s && !st_reg.idx[0] |=> st_reg.idx[0]
  ) else $error("half-step did not alternate");

  // Step counter and half-step position
  chk_steps_count: assert property (
    step_go && !wr_steps |=> st_reg.steps == $past(st_reg.steps) + `SPS_CNT_W'(1)
  ) else $error("step count missed an edge");

  chk_steps_idle: assert property (
    init_ok && !step_evt && !wr_steps |=> st_reg.steps == $past(st_reg.steps)
  ) else $error("step count moved without an edge");

  chk_steps_clear_go: assert property (
    step_go && wr_steps |=> st_reg.steps == `SPS_CNT_W'(1)
  ) else $error("step lost beside a count clear");

  chk_pos_idle: assert property (
    init_ok && !step_evt && !wr_pos |=> st_reg.pos == $past(st_reg.pos)
  ) else $error("position count moved without an edge");

  chk_pos_full_fwd: assert property (
    step_go && !wr_pos && !mode_s && !dir_s && !st_reg.idx[0]
    |=> st_reg.pos == $past(st_reg.pos) + `SPS_CNT_W'(`SPS_STEP_FULL)
  ) else $error("position count wrong on full-step forward");

  chk_pos_half_fwd: assert property (
    step_go && !wr_pos && mode_s && !dir_s
    |=> st_reg.pos == $past(st_reg.pos) + `SPS_CNT_W'(`SPS_STEP_HALF)
  ) else $error("position count wrong on half-step forward");

  chk_pos_half_rev: assert property (
    step_go && !wr_pos && mode_s && dir_s
    |=> st_reg.pos == $past(st_reg.pos) - `SPS_CNT_W'(`SPS_STEP_HALF)
  ) else $error("position count wrong on half-step reverse");

  chk_pos_full_rev: assert property (
    step_go && !wr_pos && !mode_s && dir_s && !st_reg.idx[0]
    |=> st_reg.pos == $past(st_reg.pos) - `SPS_CNT_W'(`SPS_STEP_FULL)
  ) else $error("position count wrong on full-step reverse");

  // Init reset of the position and the winding drives, and gating of the drives
  chk_init_pos_clear: assert property (
    !init_ok |=> st_reg.pos == '0
  ) else $error("init low did not clear position count");

  chk_init_outs_off: assert property (
    !init_ok |=> !O_WIND1_POS && !O_WIND1_NEG && !O_WIND2_POS && !O_WIND2_NEG
  ) else $error("winding drive on while init low");

  chk_soft_off: assert property (
    !st_reg.soft_en |=> st_reg.phase == '0
  ) else $error("outputs on while soft enable clear");

  chk_pin_off: assert property (
    !sync_q[`SPS_SY_EN] |=> st_reg.phase == '0
  ) else $error("outputs on while enable pin low");

  chk_resume_on: assert property (
    $rose(en_ok) && init_ok |=> st_reg.phase != '0
  ) else $error("outputs stayed off after enable returned");

  chk_start_idx: assert property (
    !init_ok ##1 init_ok |-> st_reg.idx == `SPS_INIT_IDX
  ) else $error("init release not at start position");

  // Shape of the excitation cycle
  chk_half_even: assert property (
    step_go && mode_s && st_reg.idx[0] |=> !st_reg.idx[0]
  ) else $error("half-step did not return to two windings");

  chk_full_odd_rev: assert property (
    step_go && !mode_s && dir_s && st_reg.idx[0]
    |=> st_reg.idx == $past(st_reg.idx) - `SPS_STEP_HALF
  ) else $error("mode change lost the position in reverse");

  chk_winding_count: assert property (
    st_reg.phase != '0
    |-> $countones(st_reg.phase) == (st_reg.idx[0] ? 1 : 2)
  ) else $error("wrong number of windings driven");

  chk_phase_opposed: assert property (
    !(O_WIND1_POS && O_WIND1_NEG)
    && !(O_WIND2_POS && O_WIND2_NEG)
  ) else $error("both ends of one winding driven");

endmodule // sps_top

// ### verif/sps_host_model.sv
// Host controller model: step clock, direction, mode, init and enable pins
// Assumes the bench calls its tasks; pin times are scaled down for simulation
`timescale 1ns/1ps
module sps_host_model (
  output logic o_step_clk,
  output logic o_dir,
  output logic o_mode,
  output logic o_init_n,
  output logic o_enable
);
  initial begin
    o_step_clk = 1'b0;
    o_dir = 1'b0;
    o_mode = 1'b0;
    o_init_n = 1'b0;
    o_enable = 1'b1;
    #7;
    // Free edges through the system reset and past its release, init still low
    repeat (10) begin
      #15 o_step_clk = 1'b1;
      #15 o_step_clk = 1'b0;
    end
    #9850 o_init_n = 1'b1;
  end

  // One step: direction and mode settle before and hold after the edge
  task automatic step(input logic dir, input logic mode);
    o_dir = dir;
    o_mode = mode;
    #40 o_step_clk = 1'b1;
    #15 o_step_clk = 1'b0;
    #40;
  endtask

  task automatic set_pins(input logic en, input logic init_n);
    o_enable = en;
    o_init_n = init_n;
  endtask
endmodule // sps_host_model

// ### verif/sps_top_bench.sv
// Bench for the phase sequencer: host model on the pins, register port tasks
// Assumes the host model owns all step-side pins
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_top_bench;
  import sps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`SPS_AW-1:0] addr = '0;
  logic [`SPS_DW-1:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [`SPS_DW-1:0] rdata;
  logic step_clk, dir, mode, init_n, enable;
  logic w1p, w1n, w2p, w2n;
  logic [3:0] pat [8] = '{`SPS_PAT0, `SPS_PAT1, `SPS_PAT2, `SPS_PAT3, `SPS_PAT4, `SPS_PAT5, `SPS_PAT6, `SPS_PAT7};
  logic [2:0] idx = 3'h0;
  logic en_exp = 1'b1;
  logic [31:0] d;
  int err_total = 0;
  int checks = 0;
  wire [3:0] ph = {w1p, w1n, w2p, w2n};

  always #2 clk = ~clk;

  sps_host_model host_u (.o_step_clk(step_clk), .o_dir(dir), .o_mode(mode), .o_init_n(init_n),
    .o_enable(enable));
  sps_top dut_u (.I_CLK(clk), .I_RST(rst), .I_STEP_CLK(step_clk), .I_ROTATION_DIRECTION_SELECT(dir),
    .I_EXCITATION_MODE(mode), .I_INIT_LOW_INPUT_N(init_n), .I_OUTPUT_ENABLE(enable), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_WIND1_POS(w1p), .O_WIND1_NEG(w1n),
    .O_WIND2_POS(w2p), .O_WIND2_NEG(w2n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Step, track the expected index, compare the winding outputs
  task automatic step(input logic sdir, input logic smode);
    logic [2:0] inc;
    // Full-step from a one-winding state moves one, to the next two-winding state
    inc = (smode || idx[0]) ? 3'h1 : 3'h2;
    host_u.step(sdir, smode);
    idx = sdir ? idx - inc : idx + inc;
    wait_clk(12);
    chk({28'h0, ph}, en_exp ? {28'h0, pat[idx]} : 32'h0);
  endtask

  task automatic test_done;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_total++;
    test_done;
  end

  initial begin
    wait_clk(45);
    rst <= 1'b0;
    #10100;
    wait_clk(12);
    chk({28'h0, ph}, {28'h0, `SPS_PAT0});
    rd(`SPS_REG_STAT, d);
    chk(d & 32'hf47, 32'h940);
    rd(`SPS_REG_CTRL, d);
    chk(d, 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h10, d);
    chk(d, 32'h0);
    rd(`SPS_REG_CTRL, d);
    chk(d, 32'h1);
    // Full forward, half forward, half reverse, full reverse
    repeat (4) step(1'b0, 1'b0);
    repeat (3) step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    repeat (2) step(1'b1, 1'b0);
    // Enable pin low keeps tracking
    host_u.set_pins(1'b0, 1'b1);
    en_exp = 1'b0;
    wait_clk(10);
    chk({28'h0, ph}, 32'h0);
    step(1'b0, 1'b1);
    host_u.set_pins(1'b1, 1'b1);
    en_exp = 1'b1;
    wait_clk(10);
    chk({28'h0, ph}, {28'h0, pat[idx]});
    // Soft enable gate
    wr(`SPS_REG_CTRL, 32'h0);
    wait_clk(3);
    chk({28'h0, ph}, 32'h0);
    wr(`SPS_REG_CTRL, 32'h1);
    // Step counter sees one count per rising edge
    wr(`SPS_REG_STEPS, 32'h0);
    repeat (2) step(1'b0, 1'b1);
    rd(`SPS_REG_STEPS, d);
    chk(d, 32'h2);
    step(1'b0, 1'b0);
    // Init low: outputs off, steps ignored, restart at index 0
    host_u.set_pins(1'b1, 1'b0);
    wait_clk(10);
    chk({28'h0, ph}, 32'h0);
    host_u.step(1'b0, 1'b1);
    wait_clk(12);
    chk({28'h0, ph}, 32'h0);
    host_u.set_pins(1'b1, 1'b1);
    idx = 3'h0;
    wait_clk(10);
    chk({28'h0, ph}, {28'h0, `SPS_PAT0});
    rd(`SPS_REG_STAT, d);
    chk(d & 32'h7, 32'h0);
    rd(`SPS_REG_POS, d);
    chk(d, 32'h0);
    wr(`SPS_REG_POS, 32'h10);
    step(1'b0, 1'b1);
    rd(`SPS_REG_POS, d);
    chk(d, 32'h11);
    rd(`SPS_REG_STAT, d);
    chk(d & 32'hf1f, 32'h809);
    step(1'b1, 1'b0);
    rd(`SPS_REG_POS, d);
    chk(d, 32'h10);
    test_done;
  end
endmodule // sps_top_bench
